/* File: hdl/pwc_regs.vh */
`ifndef PWC_REGS_VH
`define PWC_REGS_VH
// Function
// RULE1 - One 8-bit up-counter compared against an 8-bit modulo, one periodic interrupt
// RULE2 - source_select 00 low-power osc, 01 external ref, 1x internal ref; reset 00
// RULE3 - Writing a different source_select clears prescaler and count
// RULE4 - Software enables the chosen source clock before selecting it
// RULE5 - Writing a different divider_select clears prescaler and count; reset clears it
// RULE6 - Bit 0 of source_select low: off,8,32,64,128,256,512,1024,1,2,4,10,16,100,500,1000
// RULE7 - Bit 0 high: off,1024..65536 binary, then 1000..200000 decimal divides
// RULE8 - match_flag in bit 7 sets when count reaches modulo; reset clears it; code sets it one tick later, on the modulo-to-zero step
// RULE9 - Writing 1 to match_flag clears it and the request; 0 leaves it
// RULE10 - match_irq_enable in bit 4 gates the flag onto the interrupt request
// RULE11 - Counter keeps running in wait mode; interrupt can wake the processor
// RULE12 - Counter keeps running in both stop levels; interrupt can wake
// RULE13 - Low-power osc usable in both stops; reference sources only in shallow stop
// RULE14 - Debug halt freezes prescaler and counter
// RULE15 - After debug halt counting resumes from the frozen value
// RULE16 - On match count wraps to zero; flag sets on modulo-to-zero step
// RULE17 - Any modulo write clears prescaler and count
// RULE18 - Modulo zero sets match_flag on every prescaler output edge
// RULE19 - Count register is read only; writes ignored
// RULE20 - Source clocks are synchronised before the prescaler sees them
// RULE21 - Hardware set of match_flag wins over a same-cycle software clear

// Byte addresses of the registers
`define PWC_ADDR_CSC     8'h00
`define PWC_ADDR_CNT     8'h04
`define PWC_ADDR_MOD     8'h08

// Fields of counter_status_control
`define PWC_FLAG_BIT     7
`define PWC_SRC_HI       6
`define PWC_SRC_LO       5
`define PWC_IE_BIT       4
`define PWC_DIV_HI       3
`define PWC_DIV_LO       0

// Source select codes
`define PWC_SRC_LPO      2'h0
`define PWC_SRC_EXT      2'h1

// Reset values
`define PWC_RST_8        8'h00
`define PWC_RST_DIV      4'h0
`define PWC_RST_SRC      2'h0
`define PWC_PS_ZERO      18'h00000
`define PWC_PS_ONE       18'h00001
`define PWC_CNT_ONE      8'h01
`define PWC_DIV_OFF      18'h00000
`endif

/* File: hdl/pwc_edge_sync.v */
`timescale 1ns/1ps
// Two-stage synchroniser with rising edge pulse
module pwc_edge_sync
(
  // Clock and reset
  input  wire clk,
  input  wire sys_rst,
  // Asynchronous level in, pulse out
  input  wire async_in,
  output reg  rise_pulse
);
  reg meta_r;
  reg sync_r;
  reg prev_r;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r     <= 1'b0;
      sync_r     <= 1'b0;
      prev_r     <= 1'b0;
      rise_pulse <= 1'b0;
    end
    else
    begin
      meta_r     <= async_in;
      sync_r     <= meta_r;
      prev_r     <= sync_r;
      rise_pulse <= sync_r & ~prev_r;
    end
  end
endmodule

/* File: hdl/pwc_div_table.v */
`timescale 1ns/1ps
`include "pwc_regs.vh"
// Divide-by value for a divider_select code and source bit 0
module pwc_div_table
(
  // Selection
  input  wire        src_bit0,
  input  wire [3:0]  div_sel,
  // Divide ratio, zero means off
  output reg  [17:0] ratio
);
  always @*
  begin
    ratio = `PWC_DIV_OFF;
    if (!src_bit0)
    begin
      case (div_sel) // see RULE6
        4'h1: ratio = 18'h00008;
        4'h2: ratio = 18'h00020;
        4'h3: ratio = 18'h00040;
        4'h4: ratio = 18'h00080;
        4'h5: ratio = 18'h00100;
        4'h6: ratio = 18'h00200;
        4'h7: ratio = 18'h00400;
        4'h8: ratio = 18'h00001;
        4'h9: ratio = 18'h00002;
        4'hA: ratio = 18'h00004;
        4'hB: ratio = 18'h0000A;
        4'hC: ratio = 18'h00010;
        4'hD: ratio = 18'h00064;
        4'hE: ratio = 18'h001F4;
        4'hF: ratio = 18'h003E8;
        default: ratio = `PWC_DIV_OFF;
      endcase
    end
    else
    begin
      case (div_sel) // see RULE7
        4'h1: ratio = 18'h00400;
        4'h2: ratio = 18'h00800;
        4'h3: ratio = 18'h01000;
        4'h4: ratio = 18'h02000;
        4'h5: ratio = 18'h04000;
        4'h6: ratio = 18'h08000;
        4'h7: ratio = 18'h10000;
        4'h8: ratio = 18'h003E8;
        4'h9: ratio = 18'h007D0;
        4'hA: ratio = 18'h01388;
        4'hB: ratio = 18'h02710;
        4'hC: ratio = 18'h04E20;
        4'hD: ratio = 18'h0C350;
        4'hE: ratio = 18'h186A0;
        4'hF: ratio = 18'h30D40;
        default: ratio = `PWC_DIV_OFF;
      endcase
    end
  end
endmodule

/* File: hdl/pwc_top.v */
`timescale 1ns/1ps
`include "pwc_regs.vh"
// Periodic wake-up counter with APB register access
module pwc_top
(
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Source clocks, asynchronous
  input  wire        low_power_osc,
  input  wire        ext_reference_clock,
  input  wire        int_reference_clock,
  // System state
  input  wire        debug_halt,
  // Interrupt request
  output reg         match_irq
);
  reg        match_flag_r;
  reg        match_irq_enable_r;
  reg [1:0]  source_select_r;
  reg [3:0]  divider_select_r;
  reg [7:0]  counter_value_r;
  reg [7:0]  counter_modulo_r;
  reg [17:0] presc_r;
  reg        dbg_meta_r;
  reg        dbg_sync_r;

  wire       lpo_tick;
  wire       ext_tick;
  wire       int_tick;
  wire       src_tick;
  wire [17:0] ratio;
  wire       presc_out;
  wire       wr_en;
  wire       rd_en;
  wire       wr_csc;
  wire       wr_mod;
  wire       restart;
  wire       flag_clr;
  reg  [31:0] rd_mux;
  reg        addr_ok;

  // Each source sampled into the bus clock domain
  pwc_edge_sync u_sync_lpo // see RULE20
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .async_in   (low_power_osc),
    .rise_pulse (lpo_tick)
  );

  pwc_edge_sync u_sync_ext
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .async_in   (ext_reference_clock),
    .rise_pulse (ext_tick)
  );

  pwc_edge_sync u_sync_int
  (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .async_in   (int_reference_clock),
    .rise_pulse (int_tick)
  );

  pwc_div_table u_div
  (
    .src_bit0 (source_select_r[0]),
    .div_sel  (divider_select_r),
    .ratio    (ratio)
  );

  // Debug halt level synchronised
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dbg_meta_r <= 1'b0;
      dbg_sync_r <= 1'b0;
    end
    else
    begin
      dbg_meta_r <= debug_halt;
      dbg_sync_r <= dbg_meta_r;
    end
  end

  // Source mux; stop levels only gate the sources outside this block
  assign src_tick = (source_select_r == `PWC_SRC_LPO) ? lpo_tick :    // see RULE2
                    (source_select_r == `PWC_SRC_EXT) ? ext_tick :
                    int_tick;                                        // see RULE13

  // Prescaler output: one tick per ratio source edges, frozen in debug
  assign presc_out = src_tick && (ratio != `PWC_DIV_OFF) && !dbg_sync_r && // see RULE14
                     (presc_r == ratio - `PWC_PS_ONE);

  // APB decode, zero wait states
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && !penable && !pwrite;
  assign wr_csc = wr_en && (paddr == `PWC_ADDR_CSC);
  assign wr_mod = wr_en && (paddr == `PWC_ADDR_MOD);

  assign restart = wr_mod ||                                              // see RULE17
                   (wr_csc && (pwdata[`PWC_SRC_HI:`PWC_SRC_LO] != source_select_r)) || // see RULE3
                   (wr_csc && (pwdata[`PWC_DIV_HI:`PWC_DIV_LO] != divider_select_r));  // see RULE5

  assign flag_clr = wr_csc && pwdata[`PWC_FLAG_BIT];

  // Control fields
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      source_select_r    <= `PWC_RST_SRC;                        // see RULE2
      divider_select_r   <= `PWC_RST_DIV;                        // see RULE5
      match_irq_enable_r <= 1'b0;
      counter_modulo_r   <= `PWC_RST_8;
    end
    else
    begin
      if (wr_csc)
      begin
        source_select_r    <= pwdata[`PWC_SRC_HI:`PWC_SRC_LO];
        divider_select_r   <= pwdata[`PWC_DIV_HI:`PWC_DIV_LO];
        match_irq_enable_r <= pwdata[`PWC_IE_BIT];
      end
      if (wr_mod)
        counter_modulo_r <= pwdata[7:0];
    end
  end

  // Prescaler and main counter; runs in wait and stop while a source ticks
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      presc_r         <= `PWC_PS_ZERO;
      counter_value_r <= `PWC_RST_8;
    end
    else if (restart)
    begin
      presc_r         <= `PWC_PS_ZERO;
      counter_value_r <= `PWC_RST_8;
    end
    else if (src_tick && (ratio != `PWC_DIV_OFF) && !dbg_sync_r) // see RULE11 see RULE12 see RULE15
    begin
      if (presc_out)
      begin
        presc_r <= `PWC_PS_ZERO;
        if (counter_value_r == counter_modulo_r)                 // see RULE1 see RULE18
          counter_value_r <= `PWC_RST_8;                          // see RULE16
        else
          counter_value_r <= counter_value_r + `PWC_CNT_ONE;
      end
      else
        presc_r <= presc_r + `PWC_PS_ONE;
    end
  end

  // Flag: hardware set wins over software clear
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      match_flag_r <= 1'b0;                                      // see RULE8
    else if (presc_out && !restart && (counter_value_r == counter_modulo_r))
      match_flag_r <= 1'b1;                                      // see RULE21 see RULE16
    else if (flag_clr)
      match_flag_r <= 1'b0;                                      // see RULE9
  end

  // Interrupt request from registers
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      match_irq <= 1'b0;
    else
      match_irq <= match_flag_r && match_irq_enable_r &&           // see RULE10
                   !(flag_clr && !(presc_out && !restart &&
                     (counter_value_r == counter_modulo_r)));
  end

  // Read mux; count register ignores writes
  always @*
  begin
    rd_mux  = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `PWC_ADDR_CSC: rd_mux = {24'h000000, match_flag_r, source_select_r,
                               match_irq_enable_r, divider_select_r};
      `PWC_ADDR_CNT: rd_mux = {24'h000000, counter_value_r};      // see RULE19
      `PWC_ADDR_MOD: rd_mux = {24'h000000, counter_modulo_r};
      default:       addr_ok = 1'b0;
    endcase
  end

  // APB answer in the access cycle
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en)
        prdata <= rd_mux;
    end
  end
endmodule

/* File: test/pwc_assertions.sv */
`timescale 1ns/1ps
`include "pwc_regs.vh"
module pwc_checker
(
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Interrupt
  input wire        match_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire mapped = paddr == `PWC_ADDR_CSC || paddr == `PWC_ADDR_CNT || paddr == `PWC_ADDR_MOD;
  wire csc_wr = psel && penable && pwrite && paddr == `PWC_ADDR_CSC;
  pready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  pready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  pready_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_unmapped_a: assert property (pready && !mapped |-> pslverr)
    else $error("no error on unmapped address");
  err_mapped_a: assert property (pready && mapped |-> !pslverr)
    else $error("error on mapped address");
  rdata_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  rdata_unmapped_a: assert property (pready && !pwrite && !mapped |-> prdata == 32'h00000000)
    else $error("unmapped read data not zero");
  irq_clear_a: assert property (csc_wr && pwdata[7] |-> ##2 !match_irq)
    else $error("request stays after flag clear");
  irq_mask_a: assert property (csc_wr && !pwdata[4] |-> ##2 !match_irq)
    else $error("request while disabled");
  cover property ($rose(match_irq));
  cover property (pready && pslverr);
  cover property (csc_wr && pwdata[7]);
endmodule
bind pwc_top pwc_checker chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .match_irq(match_irq));

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        clk, sys_rst, psel, penable, pwrite, debug_halt, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd;
  logic [2:0]  src;
  wire  [31:0] prdata;
  wire         pready, pslverr, match_irq;
  int          miscompares, n_compared;
  int          divs [5] = '{1, 2, 4, 10, 16};
  pwc_top uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power_osc(src[0]), .ext_reference_clock(src[1]), .int_reference_clock(src[2]),
    .debug_halt(debug_halt), .match_irq(match_irq));
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, then one idle cycle
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // Rising edges on one source clock, 8 cycles each
  task pulse(input int s, input int n);
    repeat (n)
    begin
      src[s] <= 1'b1;
      repeat (4) @(posedge clk);
      src[s] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {sys_rst, psel, penable, pwrite, debug_halt} = 5'h10;
    {paddr, pwdata, src} = '0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h0);
    rdchk(8'h08, 32'h0);
    xfer(1'b0, 8'h0C, 32'h0);
    check(32'(err), 32'h1);
    xfer(1'b1, 8'h08, 32'h3);
    xfer(1'b1, 8'h00, 32'h18);
    pulse(0, 3);
    rdchk(8'h04, 32'h3);
    rdchk(8'h00, 32'h18);
    pulse(0, 1);
    rdchk(8'h04, 32'h0);
    rdchk(8'h00, 32'h98);
    check(32'(match_irq), 32'h1);
    xfer(1'b1, 8'h00, 32'h18);
    rdchk(8'h00, 32'h98);
    xfer(1'b1, 8'h00, 32'h98);
    rdchk(8'h00, 32'h18);
    check(32'(match_irq), 32'h0);
    xfer(1'b1, 8'h00, 32'h08);
    pulse(0, 4);
    rdchk(8'h00, 32'h88);
    check(32'(match_irq), 32'h0);
    pulse(0, 2);
    xfer(1'b1, 8'h04, 32'hFF);
    rdchk(8'h04, 32'h2);
    xfer(1'b1, 8'h08, 32'h0);
    rdchk(8'h04, 32'h0);
    xfer(1'b1, 8'h00, 32'h88);
    rdchk(8'h00, 32'h08);
    pulse(0, 1);
    rdchk(8'h00, 32'h88);
    // Flag clear lands on the same edge as a match
    src[0] <= 1'b1;
    repeat (2) @(posedge clk);
    xfer(1'b1, 8'h00, 32'h88);
    src[0] <= 1'b0;
    repeat (8) @(posedge clk);
    rdchk(8'h00, 32'h88);
    xfer(1'b1, 8'h08, 32'hFF);
    pulse(0, 2);
    debug_halt <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(0, 3);
    rdchk(8'h04, 32'h2);
    debug_halt <= 1'b0;
    repeat (4) @(posedge clk);
    pulse(0, 1);
    rdchk(8'h04, 32'h3);
    xfer(1'b1, 8'h00, 32'h28);
    rdchk(8'h04, 32'h0);
    pulse(1, 1000);
    rdchk(8'h04, 32'h1);
    xfer(1'b1, 8'h00, 32'h48);
    pulse(2, 3);
    pulse(0, 2);
    rdchk(8'h04, 32'h3);
    xfer(1'b1, 8'h00, 32'h68);
    pulse(2, 1000);
    rdchk(8'h04, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, 8'h00, 32'(8 + i));
      pulse(0, 16);
      rdchk(8'h04, 32'(16 / divs[i]));
    end
    xfer(1'b1, 8'h00, 32'h00);
    pulse(0, 3);
    rdchk(8'h04, 32'h0);
    xfer(1'b1, 8'h00, 32'h01);
    pulse(0, 16);
    rdchk(8'h04, 32'h2);
    test_done();
  end
endmodule
